// >>> common/ssc_pkg.sv
package ssc_pkg;
  // Register bus address width and register byte offsets
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00; // Transfer control
  localparam logic [7:0] TX_OFS = 8'h08; // Transmit word
  localparam logic [7:0] RX_OFS = 8'h0c; // Received word
  localparam logic [7:0] STAT_OFS = 8'h10; // Sticky event status
  localparam logic [7:0] MASK_OFS = 8'h14; // Event mask

  // Control register field positions
  localparam int unsigned GO_BIT = 0;
  localparam int unsigned RXNEG_BIT = 1;
  localparam int unsigned TXNEG_BIT = 2;
  localparam int unsigned LEN_LSB = 3;
  localparam int unsigned LSB_BIT = 10;
  localparam int unsigned CPOL_BIT = 11;
  localparam int unsigned GAP_LSB = 12;
  localparam int unsigned FLAG_BIT = 16;
  localparam int unsigned IE_BIT = 17;
  localparam int unsigned SLAVE_BIT = 18;

  // Reset values
  localparam logic [3:0] GAP_RST = 4'h3;
  localparam logic [4:0] LEN_RST = 5'h00;

  // Timing: aclk period, default bus clock half period
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned SCLK_HALF_NS = 80;
  localparam int unsigned SCLK_HALF_CYC = SCLK_HALF_NS / CLK_NS;
  // Extra idle with variable clock and data waiting: 6.5 cycles less one half, in halves
  localparam int unsigned VAR_GAP_X10 = 65;
  localparam logic [5:0] VAR_GAP_HALVES = 6'(VAR_GAP_X10 * 2 / 10 - 1);

  // Bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Shift engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_GAP = 3'b010,
    ST_SHIFT = 3'b100
  } ssc_state_t;
endpackage : ssc_pkg

// >>> dv/spi_shift_control_test.sv
`timescale 1ns/1ns
// Self-checking bench for the serial transfer control block
module spi_shift_control_test;
  import ssc_pkg::*;
  localparam int H = 4; // aclk cycles per bus clock half
  // Clock, reset and register bus
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  // Serial pins and neighbour inputs
  logic sclk_i = 0, sclk_o, sclk_oe_n, sdo, sdi;
  logic fifo_mode = 0, var_clk_en = 0, tx_fifo_not_empty = 0;
  logic unit_done, irq;
  // Far-side model controls
  logic p_start = 0, p_tf = 0, p_rf = 1, p_lsb = 0, p_sl = 0;
  logic [5:0] p_nb = 6'h08;
  logic [31:0] p_tx = '0, got;
  wire logic link_clk = sclk_oe_n ? sclk_i : sclk_o;
  // Counters and edge monitor state
  int errors = 0;
  int checks_done = 0;
  int cyc = 0, ecyc = 0, ecnt = 0, gap_m = 0, ndone = 0;
  bit gp = 0;
  logic ck_q = 0, sdo_q = 0, efell = 0;

  ssc_ctrl #(.SCLK_HALF(H)) u_dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .sclk_i, .sclk_o,
    .sclk_oe_n, .sdo, .sdi, .fifo_mode, .var_clk_en,
    .tx_fifo_not_empty, .unit_done, .irq
  );

  ssc_peer u_peer (
    .start(p_start), .nbits(p_nb), .tx_word(p_tx), .tx_fall(p_tf),
    .rx_fall(p_rf), .lsb(p_lsb), .sclk(link_clk), .sdo(sdo), .sdi(sdi),
    .got(got)
  );

  initial begin
    forever #10 aclk = ~aclk;
  end

  // Verdict and end of run
  task automatic stop_test;
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // One comparison
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk

  // Bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dat,
                    output logic [1:0] resp);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  // Bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] dat,
                    output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    dat = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // Poll the busy bit; bounded so a stuck bit shows as a mismatch
  task automatic wait_idle;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    d = 32'h1;
    while (d[0] !== 1'b0 && n < 400) begin
      rd(CTRL_OFS, d, r);
      n++;
    end
    chk(32'(d[0]), 32'h0);
  endtask : wait_idle

  // External master's clock, phase unrelated to aclk, only within a frame
  task automatic run_link(input int n);
    #7;
    repeat (2 * n) begin
      #80;
      sclk_i = ~sclk_i;
    end
    // Bus requests that follow must start just after an aclk edge
    @(posedge aclk);
  endtask : run_link

  // Bits of a word that travel; untouched high bits read back as zero
  function automatic logic [31:0] keep(input int n, input logic [31:0] v);
    return n >= 32 ? v : v & ((32'h1 << n) - 32'h1);
  endfunction : keep

  // Edge monitor: launch edge kind, gap between words, edge count
  always @(posedge aclk) begin
    if (link_clk !== ck_q) begin
      if (gp) gap_m = cyc - ecyc;
      gp = 0;
      ecyc = cyc;
      efell = !link_clk;
      ecnt++;
    end
    if (unit_done === 1'b1) begin
      gp = 1;
      ndone++;
    end
    if (sdo !== sdo_q && ecnt > 0 && ecnt < 2 * int'(p_nb)) begin
      chk(32'(efell), 32'(p_tf));
      chk(32'(cyc - ecyc <= 4), 32'h1);
    end
    ck_q = link_clk;
    sdo_q = sdo;
    cyc++;
  end

  // Hang guard, well past the expected run length
  initial begin
    #2000000;
    errors++;
    stop_test;
  end

  initial begin
    int seed, nb, n;
    logic [31:0] d, cfg, dtx;
    logic [1:0] r;
    logic sl, ie, cp, ls, tf;
    logic [3:0] g;
    logic [4:0] len;
    seed = $urandom(12017);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(CTRL_OFS, d, r);
    chk(d, {16'h0, GAP_RST, 4'h0, LEN_RST, 3'h0});
    // Unmapped place answers with an error and no data
    rd(8'h04, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(8'h04, 32'hffff_ffff, r);
    chk(32'(r), 32'(RESP_SLVERR));
    // Single words, both roles, both orders, opposite launch and sample edges, lengths 32, 8 and 8 to 31
    for (int i = 0; i < 10; i++) begin
      sl = 1'($urandom);
      ie = 1'($urandom);
      cp = 1'($urandom);
      ls = 1'($urandom);
      tf = 1'($urandom);
      g = 4'($urandom);
      len = i == 0 ? 5'h00 : i == 1 ? 5'h08 : 5'($urandom_range(31, 8));
      nb = len == 5'h00 ? 32 : int'(len);
      dtx = $urandom;
      p_tx <= $urandom;
      cfg = {13'h0, sl, ie, 1'b0, g, cp, ls, 2'h0, len, tf, ~tf, 1'b0};
      p_sl <= sl;
      p_nb <= 6'(nb);
      p_tf <= tf;
      p_rf <= ~tf;
      p_lsb <= ls;
      sclk_i <= cp;
      wr(TX_OFS, dtx, r);
      chk(32'(r), 32'(RESP_OKAY));
      wr(CTRL_OFS, cfg, r);
      rd(CTRL_OFS, d, r);
      chk(d, cfg);
      chk(32'(sclk_oe_n), 32'(sl));
      if (!sl) chk(32'(sclk_o), 32'(cp));
      p_start <= 1'b1;
      ecnt = 0;
      ndone = 0;
      wr(CTRL_OFS, cfg | 32'h1, r);
      p_start <= 1'b0;
      rd(CTRL_OFS, d, r);
      chk(32'(d[0]), 32'h1);
      if (sl) run_link(nb);
      wait_idle;
      rd(RX_OFS, d, r);
      chk(32'(r), 32'(RESP_OKAY));
      chk(d, keep(nb, p_tx));
      chk(32'(ndone), 32'h1);
      chk(got, keep(nb, dtx));
      if (!sl) chk(32'(ecnt), 32'(2 * nb));
      if (!sl) chk(32'(sclk_o), 32'(cp));
      rd(STAT_OFS, d, r);
      chk(32'(d[0]), 32'h1);
      chk(32'(irq), 32'(ie));
      rd(MASK_OFS, d, r);
      chk(d, 32'(ie));
      // Odd rounds clear through the control register's mirror bit
      if (i % 2) wr(CTRL_OFS, cfg | (32'h1 << FLAG_BIT), r);
      else wr(STAT_OFS, 32'h1, r);
      chk(32'(irq), 32'h0);
      rd(STAT_OFS, d, r);
      chk(d, 32'h0);
    end
    // FIFO master: two words back to back, plain and variable clock
    for (int v = 0; v < 2; v++) begin
      g = 4'($urandom);
      cfg = {16'h0, g, 4'h0, 5'h08, 3'h0};
      p_sl <= 1'b0;
      wr(CTRL_OFS, cfg, r);
      // Monitor reference for this setup; let any level change settle
      p_tf <= 1'b0;
      p_nb <= 6'h08;
      @(posedge aclk);
      ecnt = 0;
      gp = 0;
      gap_m = -1;
      fifo_mode <= 1'b1;
      var_clk_en <= 1'(v);
      tx_fifo_not_empty <= 1'b1;
      n = 0;
      while (gap_m < 0 && n < 5000) begin
        @(posedge aclk);
        n++;
      end
      tx_fifo_not_empty <= 1'b0;
      chk(32'(gap_m), 32'((2 * g + 1 + 12 * v) * H));
      rd(CTRL_OFS, d, r);
      chk(32'(d[0]), 32'h1);
      wait_idle;
    end
    // FIFO master, idle, nothing waiting: a go write must not start
    wr(CTRL_OFS, 32'h1, r);
    rd(CTRL_OFS, d, r);
    chk(32'(d[0]), 32'h0);
    // FIFO slave: busy bit always reads one
    wr(CTRL_OFS, 32'h1 << SLAVE_BIT, r);
    rd(CTRL_OFS, d, r);
    chk(32'(d[0]), 32'h1);
    fifo_mode <= 1'b0;
    stop_test;
  end
endmodule : spi_shift_control_test

// >>> dv/ssc_peer.sv
`timescale 1ns/1ns
// Far-side serial device: sends one word on sdi, captures sdo
module ssc_peer (
  // Frame control from the bench
  input wire logic start,
  input wire logic [5:0] nbits,
  input wire logic [31:0] tx_word,
  // Edge and order choices, mirrored from the controller setup
  input wire logic tx_fall,
  input wire logic rx_fall,
  input wire logic lsb,
  // Serial pins
  input wire logic sclk,
  input wire logic sdo,
  output logic sdi,
  // Word captured from sdo
  output logic [31:0] got
);
  int idx = 32; // Bit now on sdi
  int ncap = 32; // Bits captured so far
  bit armed = 0; // Controller has sampled at least once
  logic fell;

  // Wire position of the k-th bit of a word
  function automatic int pos(input int k);
    return lsb ? k : int'(nbits) - 1 - k;
  endfunction : pos

  initial sdi = 1'b0;

  // Frame start: first bit must sit on sdi before the first sample edge
  always @(posedge start) begin
    idx = 0;
    ncap = 0;
    armed = 0;
    got = '0;
    sdi = tx_word[pos(0)];
  end

  // Capture on the edge the controller does not launch on; launch on
  // the edge it does not sample on, but only after its first sample
  always @(sclk) begin
    fell = (sclk === 1'b0);
    if (fell != tx_fall && ncap < int'(nbits)) begin
      got[pos(ncap)] = sdo;
      ncap++;
    end
    if (fell == rx_fall) begin
      armed = 1;
    end else if (armed && idx + 1 < int'(nbits)) begin
      idx++;
      sdi = tx_word[pos(idx)];
    end else if (armed) begin
      // Hold time over: leave no stale bit for the controller to trust
      sdi = ~sdi;
    end
  end
endmodule : ssc_peer

// >>> rtl/ssc_ctrl.sv
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module ssc_ctrl
  import ssc_pkg::*;
#(
  parameter int unsigned SCLK_HALF = ssc_pkg::SCLK_HALF_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [ssc_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [ssc_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Serial bus pins
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe_n,
  output logic sdo,
  input wire logic sdi,
  // Neighbouring FIFO and clock logic
  input wire logic fifo_mode,
  input wire logic var_clk_en,
  input wire logic tx_fifo_not_empty,
  output logic unit_done,
  // Interrupt
  output logic irq
);
  // All block state
  typedef struct packed {
    ssc_state_t st;
    logic [3:0] gap; // Word gap setting
    logic cpol; // Clock idle polarity
    logic lsb; // Low bit first
    logic [4:0] len; // Word length
    logic txneg; // Launch on falling
    logic rxneg; // Sample on falling
    logic go; // Go/busy
    logic flag; // Unit done, sticky
    logic ie; // Unit done interrupt enable
    logic slave; // Role select
    logic [31:0] tx; // Transmit word
    logic [31:0] rx; // Last received word
    logic [31:0] rsh; // Word being received
    logic [7:0] hcnt; // Half-period divider
    logic [6:0] tog; // Bus clock toggles this word
    logic [5:0] sidx; // Bits sampled
    logic [5:0] tidx; // Bit now driven
    logic [5:0] gcnt; // Gap halves left
    logic pend; // Sampled since last launch
    logic lvl; // Driven bus clock level
    logic sdo; // Serial out
    logic done; // Word finished pulse
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ssc_regs_t;

  ssc_regs_t s_q;
  ssc_regs_t s_d;

  // Synchronised pins: bit 1 bus clock, bit 0 data in
  logic [1:0] pin_lvl;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;

  // Combinational helpers
  logic rise_ev;
  logic fall_ev;
  logic launch_ev;
  logic samp_ev;
  logic [5:0] nb;
  logic half_end;
  logic wr_fire;
  logic start;
  logic go_view;
  logic [31:0] ctrl_view;
  logic [31:0] nw;
  logic [5:0] gload;

  // Bits per word from the length field
  function automatic logic [5:0] ssc_bits(input logic [4:0] len);
    ssc_bits = (len == 5'h00) ? 6'h20 : {1'b0, len};
  endfunction : ssc_bits

  // Word bit position of the idx-th bit on the wire
  function automatic logic [4:0] ssc_pos(input logic lsb,
                                         input logic [5:0] nbits,
                                         input logic [5:0] idx);
    logic [5:0] p;
    p = lsb ? idx : 6'(nbits - 6'h01 - idx);
    ssc_pos = p[4:0];
  endfunction : ssc_pos

  // Merge a bus write into a word under byte strobes
  function automatic logic [31:0] ssc_merge(input logic [31:0] old,
                                            input logic [31:0] nv,
                                            input logic [3:0] stb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (stb[i]) begin
        r[8*i +: 8] = nv[8*i +: 8];
      end
    end
    ssc_merge = r;
  endfunction : ssc_merge

  // Pins from the far side cross into aclk first
  ssc_sync #(.W(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({sclk_i, sdi}),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // Go/busy as software sees it
  always_comb begin
    if (fifo_mode) begin
      go_view = s_q.slave ? 1'b1 : (s_q.st != ST_IDLE);
    end else begin
      go_view = s_q.go;
    end
    ctrl_view = '0;
    ctrl_view[GO_BIT] = go_view;
    ctrl_view[RXNEG_BIT] = s_q.rxneg;
    ctrl_view[TXNEG_BIT] = s_q.txneg;
    ctrl_view[LEN_LSB +: 5] = s_q.len;
    ctrl_view[LSB_BIT] = s_q.lsb;
    ctrl_view[CPOL_BIT] = s_q.cpol;
    ctrl_view[GAP_LSB +: 4] = s_q.gap;
    ctrl_view[FLAG_BIT] = s_q.flag;
    ctrl_view[IE_BIT] = s_q.ie;
    ctrl_view[SLAVE_BIT] = s_q.slave;
  end

  // Next-state logic for bus slave and shift engine
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    start = 1'b0;
    nb = ssc_bits(s_q.len);
    half_end = (s_q.hcnt == 8'(SCLK_HALF - 1));
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    nw = ssc_merge(ctrl_view, s_q.wdat, s_q.wstb);
    // Gap in half cycles beyond the first half of the next word
    gload = {1'b0, s_q.gap, 1'b0};
    if (var_clk_en && tx_fifo_not_empty) begin
      gload = 6'(gload + VAR_GAP_HALVES);
    end

    // Write address and data are taken in either order
    if (awvalid && awready) begin
      s_d.aw_got = 1'b1;
      s_d.waddr = awaddr;
    end
    if (wvalid && wready) begin
      s_d.w_got = 1'b1;
      s_d.wdat = wdata;
      s_d.wstb = wstrb;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;

    // Register writes
    if (wr_fire) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      case (s_q.waddr)
        CTRL_OFS: begin
          s_d.rxneg = nw[RXNEG_BIT];
          s_d.txneg = nw[TXNEG_BIT];
          s_d.len = nw[LEN_LSB +: 5];
          s_d.lsb = nw[LSB_BIT];
          s_d.cpol = nw[CPOL_BIT];
          s_d.gap = nw[GAP_LSB +: 4];
          s_d.ie = nw[IE_BIT];
          s_d.slave = nw[SLAVE_BIT];
          if (s_q.wstb[2] && s_q.wdat[FLAG_BIT]) begin
            s_d.flag = 1'b0;
          end
          // Go is ignored in FIFO mode and while a word runs
          if (!fifo_mode && s_q.wstb[0] && s_q.wdat[GO_BIT] &&
              s_q.st == ST_IDLE) begin
            s_d.go = 1'b1;
            start = 1'b1;
          end
        end
        TX_OFS: s_d.tx = ssc_merge(s_q.tx, s_q.wdat, s_q.wstb);
        RX_OFS: s_d.bresp = RESP_OKAY;
        STAT_OFS: begin
          if (s_q.wstb[0] && s_q.wdat[0]) begin
            s_d.flag = 1'b0;
          end
        end
        MASK_OFS: begin
          if (s_q.wstb[0]) begin
            s_d.ie = s_q.wdat[0];
          end
        end
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end

    // Register reads, answered one cycle after the address
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      case (araddr)
        CTRL_OFS: s_d.rdata = ctrl_view;
        TX_OFS: s_d.rdata = s_q.tx;
        RX_OFS: s_d.rdata = s_q.rx;
        STAT_OFS: s_d.rdata = {31'h0, s_q.flag};
        MASK_OFS: s_d.rdata = {31'h0, s_q.ie};
        default: begin
          s_d.rdata = '0;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end

    // FIFO master starts on its own when data waits
    if (fifo_mode && !s_q.slave && s_q.st == ST_IDLE &&
        tx_fifo_not_empty) begin
      start = 1'b1;
    end

    // Bus clock edges: made here as master, seen on the pin as slave
    if (s_q.slave) begin
      rise_ev = (s_q.st == ST_SHIFT) && pin_rise[1];
      fall_ev = (s_q.st == ST_SHIFT) && pin_fall[1];
    end else if (s_q.st == ST_IDLE) begin
      s_d.lvl = s_q.cpol;
      s_d.hcnt = '0;
    end else begin
      s_d.hcnt = half_end ? 8'h00 : 8'(s_q.hcnt + 8'h01);
      if (s_q.st == ST_SHIFT && half_end) begin
        s_d.lvl = ~s_q.lvl;
        rise_ev = ~s_q.lvl;
        fall_ev = s_q.lvl;
        s_d.tog = 7'(s_q.tog + 7'h01);
      end
    end
    launch_ev = s_q.txneg ? fall_ev : rise_ev;
    samp_ev = s_q.rxneg ? fall_ev : rise_ev;

    // Engine states
    case (s_q.st)
      ST_IDLE: s_d.st = ST_IDLE;
      ST_GAP: begin
        if (half_end) begin
          s_d.gcnt = 6'(s_q.gcnt - 6'h01);
          if (s_q.gcnt == 6'h01) begin
            start = 1'b1;
          end
        end
      end
      ST_SHIFT: begin
        // Advance the out bit only after the previous one was sampled
        if (launch_ev && s_q.pend) begin
          s_d.tidx = 6'(s_q.tidx + 6'h01);
          s_d.pend = 1'b0;
        end
        if (samp_ev) begin
          s_d.rsh[ssc_pos(s_q.lsb, nb, s_q.sidx)] = pin_lvl[0];
          s_d.sidx = 6'(s_q.sidx + 6'h01);
          s_d.pend = 1'b1;
        end
        // Master ends on the last toggle, back at the idle level
        if ((!s_q.slave && s_d.tog == {nb, 1'b0}) ||
            (s_q.slave && s_d.sidx == nb)) begin
          s_d.done = 1'b1;
          s_d.rx = s_d.rsh;
          s_d.st = ST_IDLE;
          if (!fifo_mode) begin
            s_d.go = 1'b0;
          end else if (s_q.slave) begin
            start = 1'b1;
          end else if (tx_fifo_not_empty) begin
            if (gload == 6'h00) begin
              start = 1'b1;
            end else begin
              s_d.st = ST_GAP;
              s_d.gcnt = gload;
              s_d.hcnt = '0;
            end
          end
        end
      end
      default: s_d.st = ST_IDLE;
    endcase

    // Load a fresh word; first bit goes out before the first edge
    if (start) begin
      s_d.st = ST_SHIFT;
      s_d.hcnt = '0;
      s_d.tog = '0;
      s_d.sidx = '0;
      s_d.tidx = '0;
      s_d.pend = 1'b0;
      s_d.rsh = '0;
      s_d.lvl = s_q.cpol;
    end

    // Unit done sets the sticky flag; set beats a clear
    if (s_d.done) begin
      s_d.flag = 1'b1;
    end

    // Serial out follows the bit index, first bit chosen by order
    if (s_d.st == ST_SHIFT) begin
      s_d.sdo = s_d.tx[ssc_pos(s_q.lsb, nb, s_d.tidx)];
    end
  end

  // State register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.gap <= GAP_RST;
      s_q.len <= LEN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign awready = !s_q.aw_got && !s_q.bvalid;
  assign wready = !s_q.w_got && !s_q.bvalid;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = !s_q.rvalid;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign sclk_o = s_q.lvl;
  assign sclk_oe_n = s_q.slave;
  assign sdo = s_q.sdo;
  assign unit_done = s_q.done;
  assign irq = s_q.flag && s_q.ie;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_go_write;
    wr_fire && s_q.waddr == CTRL_OFS && s_q.wstb[0] && s_q.wdat[GO_BIT] &&
      !fifo_mode && s_q.st == ST_IDLE;
  endsequence

  property p_idle_level;
    !s_q.slave && s_q.st == ST_IDLE ##1 s_q.st == ST_IDLE
      |-> sclk_o == $past(s_q.cpol);
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("bus clock not at idle level");

  property p_go_starts;
    s_go_write |=> s_q.st == ST_SHIFT && go_view ##1 s_q.tog == 7'h00;
  endproperty
  a_go_starts: assert property (p_go_starts)
    else $error("go write did not start a word");

  property p_slave_arm;
    s_go_write and s_q.slave |=> s_q.st == ST_SHIFT && sclk_oe_n;
  endproperty
  a_slave_arm: assert property (p_slave_arm)
    else $error("slave not armed by go");

  property p_go_clears;
    s_q.done && !fifo_mode |-> !go_view && s_q.flag;
  endproperty
  a_go_clears: assert property (p_go_clears)
    else $error("go stayed set after word");

  property p_fifo_slave_go;
    fifo_mode && s_q.slave |-> ctrl_view[GO_BIT];
  endproperty
  a_fifo_slave_go: assert property (p_fifo_slave_go)
    else $error("fifo slave go reads zero");

  property p_fifo_ignores_go;
    wr_fire && fifo_mode && s_q.st == ST_IDLE && !tx_fifo_not_empty &&
      !s_q.slave |=> s_q.st == ST_IDLE;
  endproperty
  a_fifo_ignores_go: assert property (p_fifo_ignores_go)
    else $error("fifo mode go write started a word");

  property p_gap_load;
    !s_q.slave && s_q.st == ST_SHIFT ##1 s_q.st == ST_GAP
      |-> s_q.gcnt == 6'({$past(s_q.gap), 1'b0} +
          (($past(var_clk_en) && $past(tx_fifo_not_empty)) ?
           VAR_GAP_HALVES : 6'h00));
  endproperty
  a_gap_load: assert property (p_gap_load)
    else $error("word gap length wrong");

  property p_word_len;
    s_q.done && !s_q.slave |-> s_q.tog == {ssc_bits(s_q.len), 1'b0};
  endproperty
  a_word_len: assert property (p_word_len)
    else $error("word bit count wrong");

  property p_launch_edge;
    // A fresh word reloads the index; that is no launch
    !start && s_q.st == ST_SHIFT && s_d.st == ST_SHIFT &&
      s_d.tidx != s_q.tidx
      |-> (s_q.txneg ? fall_ev : rise_ev);
  endproperty
  a_launch_edge: assert property (p_launch_edge)
    else $error("data out moved off its edge");

  property p_sample_edge;
    s_q.st == ST_SHIFT && !start && s_d.sidx != s_q.sidx
      |-> (s_q.rxneg ? fall_ev : rise_ev);
  endproperty
  a_sample_edge: assert property (p_sample_edge)
    else $error("data in sampled off its edge");

  property p_bit_order;
    s_q.st == ST_SHIFT ##1 s_q.st == ST_SHIFT && $stable(s_q.tidx)
      && $stable(s_q.tx) && $stable(s_q.lsb)
      |-> sdo == s_q.tx[ssc_pos(s_q.lsb, ssc_bits(s_q.len), s_q.tidx)];
  endproperty
  a_bit_order: assert property (p_bit_order)
    else $error("serial out bit order wrong");

  property p_irq;
    s_q.done |-> s_q.flag ##0 (irq == s_q.ie);
  endproperty
  a_irq: assert property (p_irq)
    else $error("unit done flag or interrupt wrong");
endmodule : ssc_ctrl

// >>> rtl/ssc_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser with edge detection on the settled level
module ssc_sync #(
  parameter int unsigned W = 2
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Asynchronous inputs
  input wire logic [W-1:0] din,
  // Synchronised level and one-cycle edge pulses
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  // Three stages; only the second stage reads the first
  typedef struct packed {
    logic [W-1:0] m1;
    logic [W-1:0] m2;
    logic [W-1:0] m3;
  } ssc_sync_t;

  ssc_sync_t s_q;
  ssc_sync_t s_d;

  // Next-state: shift along the chain
  always_comb begin
    s_d = s_q;
    s_d.m1 = din;
    s_d.m2 = s_q.m1;
    s_d.m3 = s_q.m2;
  end

  // Registers, cleared synchronously
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Edges compare settled stages only
  assign lvl = s_q.m2;
  assign rise = s_q.m2 & ~s_q.m3;
  assign fall = ~s_q.m2 & s_q.m3;
endmodule : ssc_sync
